// File: axil_slave.sv
// AXI4-Lite slave front end that turns bus traffic into register strobes.
`timescale 1ns/100ps
`default_nettype none
module axil_slave
  import irq_prio_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data channels.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side.
  output logic wr_fire,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_lane,
  input wire logic wr_hit,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);

  logic aw_held;
  logic w_held;
  logic [3:0] strb;

  // Each channel is open while its half is empty and no response waits.
  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign arready = ~rvalid;
  assign wr_fire = aw_held & w_held & ~bvalid;
  assign wr_lane = strb[0];
  assign rd_addr = araddr;

  // Write path: capture address and data in either order, then respond.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata[7:0];
        strb <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read path: answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_data};
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // axil_slave
`default_nettype wire

// File: edge_detect.sv
// Edge detector for one external interrupt pin with selectable polarity.
`timescale 1ns/100ps
`default_nettype none
module edge_detect
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and edge select.
  input wire logic pin,
  input wire logic rising,
  // Event.
  output logic fire
);

  logic prev;

  // The previous sample starts at the pin level so reset makes no edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= pin;
    end else begin
      prev <= pin;
    end
  end

  // A rising edge counts when the select is one, a falling one otherwise.
  assign fire = rising ? (pin & ~prev) : (~pin & prev); // [R8]

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_edge_rise;
    rising && $past(aresetn) && $rose(pin) |-> fire;
  endproperty
  a_edge_rise: assert property (p_edge_rise) // [R8]
    else $error("rising edge missed");

  property p_edge_fall;
    !rising && $fell(pin) |-> fire;
  endproperty
  a_edge_fall: assert property (p_edge_fall) // [R8]
    else $error("falling edge missed");

endmodule // edge_detect
`default_nettype wire

// File: irq_core_model.sv
// Behavioural model of the processor core that takes interrupts.
`timescale 1ns/100ps
`default_nettype none
module irq_core_model #(
  parameter int LATENCY = 2
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control.
  input wire logic accept,
  input wire logic ret_go,
  // Request lines.
  input wire logic irq_high,
  input wire logic irq_low,
  // Take and return.
  output logic irq_take,
  output logic irq_take_high,
  output logic irq_return,
  // Live core state.
  output logic [20:0] core_pc,
  output logic [7:0] core_work,
  output logic [7:0] core_status,
  output logic [7:0] core_bank
);
  logic taken;
  logic [3:0] wait_cnt;

  // State moves every cycle, so a capture on the wrong edge shows up.
  // One take per accept window, after LATENCY cycles of waiting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_pc <= 21'h0;
      core_work <= 8'h11;
      core_status <= 8'h22;
      core_bank <= 8'h33;
      irq_take <= 1'h0;
      irq_take_high <= 1'h0;
      irq_return <= 1'h0;
      taken <= 1'h0;
      wait_cnt <= 4'h0;
    end else begin
      core_pc <= core_pc + 21'h1;
      core_work <= core_work + 8'h3;
      core_status <= core_status + 8'h7;
      core_bank <= core_bank + 8'h1;
      irq_take <= 1'h0;
      irq_return <= ret_go;
      if (!accept) begin
        taken <= 1'h0;
        wait_cnt <= 4'h0;
      end else if (!taken && (irq_high || irq_low)) begin
        if (wait_cnt == 4'(LATENCY)) begin
          irq_take <= 1'h1;
          irq_take_high <= irq_high;
          taken <= 1'h1;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule // irq_core_model
`default_nettype wire

// File: irq_prio_core.sv
// Prioritised interrupt sources, reset cause register and context capture.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R1] Group-2 priority bits 7,6,3,2,1 are writable, one high, reset to one.
// [R2] Group-2 bits 5,4 and 0 read zero and ignore writes.
// [R3] Group-3 bit 6 is display priority, writable, reset to zero.
// [R4] Group-3 bits 5,4 are aux serial priorities, read-only, reset zero.
// [R5] Group-3 bits 2,1 capture/compare priorities reset to one; 7,3,0 read zero.
// [R6] Reset-control bit 7 enables two priority levels; zero gives single level.
// [R7] Reset-control holds five cause flags with given access; bits 6,5 zero.
// [R8] Each external pin triggers on rising or falling edge per polarity bit.
// [R9] A valid pin edge sets its flag; a cleared enable blocks the interrupt.
// [R10] Software clears a pin flag in its handler before re-enabling.
// [R11] An enabled pin flag wakes the core; global enable then allows vectoring.
// [R12] External one, two, three priorities come from dedicated control bits.
// [R13] External zero has no priority bit and is always high priority.
// [R14] Timer0 flag sets on wrap from FF or FFFF by mode.
// [R15] Timer0 enable is main bit 5; priority is second-control bit 2.
// [R16] Port B pins 7..4 change sets main bit 0; enable bit 3.
// [R17] Taking an interrupt pushes the return PC and saves W, status, bank.
// [R18] Without fast return, software saves working registers itself.
// [R19] Single level mode needs the peripheral enable for peripheral sources.
// [R20] Priority bits only matter when priority levels are enabled.
// [R21] Sources route to high or low line; high preempts low service.
module irq_prio_core
  import irq_prio_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register bus.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Event sources.
  input wire logic [3:0] ext_pins,
  input wire logic [7:4] port_b_pins,
  input wire logic timer0_tick,
  input wire logic [7:0] periph_pending2,
  input wire logic [7:0] periph_pending3,
  // Core side.
  output logic irq_high,
  output logic irq_low,
  output logic wake,
  input wire logic irq_take,
  input wire logic irq_take_high,
  input wire logic irq_return,
  input wire logic [20:0] core_pc,
  input wire logic [7:0] core_work,
  input wire logic [7:0] core_status,
  input wire logic [7:0] core_bank,
  // Context capture.
  output logic stack_push,
  output logic [20:0] stack_pc,
  output logic [7:0] fast_work,
  output logic [7:0] fast_status,
  output logic [7:0] fast_bank
);

  logic [7:0] ppg2;
  logic [7:0] ppg3;
  logic [7:0] rcpc;
  logic [7:0] mic;
  logic [7:0] sic;
  logic [7:0] tic;
  logic [7:0] t0ctl;
  logic [15:0] t0count;
  logic [7:4] rb_prev;
  logic in_high;
  logic in_low;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane;
  logic wr_hit;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_hit;
  logic [3:0] ext_evt;

  // Bus front end.
  axil_slave u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_fire(wr_fire), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_lane(wr_lane), .wr_hit(wr_hit),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit)
  );

  // One edge detector per external pin; polarity comes from second control.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      edge_detect u_edge (
        .aclk(aclk), .aresetn(aresetn),
        .pin(ext_pins[gi]),
        .rising(sic[SIC_POL_LSB + gi]), // [R8]
        .fire(ext_evt[gi])
      );
    end
  endgenerate

  // Write decode.
  wire wr_en = wr_fire & wr_lane;
  wire wr_ppg2 = wr_en && wr_addr == OFF_PPG2;
  wire wr_ppg3 = wr_en && wr_addr == OFF_PPG3;
  wire wr_rcpc = wr_en && wr_addr == OFF_RCPC;
  wire wr_mic = wr_en && wr_addr == OFF_MIC;
  wire wr_sic = wr_en && wr_addr == OFF_SIC;
  wire wr_tic = wr_en && wr_addr == OFF_TIC;
  wire wr_t0ctl = wr_en && wr_addr == OFF_T0CTL;
  assign wr_hit = wr_addr == OFF_PPG2 || wr_addr == OFF_PPG3 ||
                  wr_addr == OFF_RCPC || wr_addr == OFF_MIC ||
                  wr_addr == OFF_SIC || wr_addr == OFF_TIC ||
                  wr_addr == OFF_T0CTL;

  // Timer0 wrap detection for 8-bit and 16-bit modes.
  wire mode16 = t0ctl[T0CTL_MODE16];
  wire t0_wrap = timer0_tick & (mode16 ? t0count == T0_WRAP16
                                       : t0count[7:0] == T0_WRAP8); // [R14]
  wire [15:0] next_t0count = mode16 ? t0count + 16'h0001
      : {t0count[15:8], t0count[7:0] + 8'h01};
  wire rb_change = port_b_pins != rb_prev; // [R16]

  // Flag registers: a hardware event wins over a software clear.
  wire [7:0] mic_set = {5'h00, t0_wrap, ext_evt[0], rb_change};
  wire [7:0] tic_set = {5'h00, ext_evt[3:1]};
  wire [7:0] next_mic = (wr_mic ? wr_data : mic) | mic_set; // [R9] [R16]
  wire [7:0] next_tic = (wr_tic ? wr_data : tic) | tic_set; // [R9]

  // Configuration registers with their writable masks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ppg2 <= PPG2_RST;
      ppg3 <= PPG3_RST;
      rcpc <= RCPC_RST;
      sic <= SIC_RST;
      t0ctl <= T0CTL_RST;
    end else begin
      if (wr_ppg2) ppg2 <= wr_data & PPG2_WMASK; // [R1] [R2]
      if (wr_ppg3) ppg3 <= (ppg3 & ~PPG3_WMASK) |
                          (wr_data & PPG3_WMASK); // [R3] [R4] [R5]
      if (wr_rcpc) rcpc <= (rcpc & ~RCPC_WMASK) |
                          (wr_data & RCPC_WMASK); // [R6] [R7]
      if (wr_sic) sic <= wr_data & SIC_WMASK;
      if (wr_t0ctl) t0ctl <= wr_data & T0CTL_WMASK;
    end
  end

  // Flags, timer and port B sample.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mic <= MIC_RST;
      tic <= TIC_RST;
      t0count <= 16'h0000;
      rb_prev <= port_b_pins;
    end else begin
      mic <= next_mic;
      tic <= next_tic;
      if (timer0_tick) t0count <= next_t0count;
      rb_prev <= port_b_pins;
    end
  end

  // Per-source pending and priority for the core-level sources.
  wire [6:0] core_pend = {
    mic[MIC_T0F] & mic[MIC_T0E], // [R15]
    mic[MIC_RBF] & mic[MIC_RBE], // [R16]
    mic[MIC_X0F] & mic[MIC_X0E],
    tic[TIC_FLAG_LSB +: 3] & tic[TIC_EN_LSB +: 3], // [R9]
    1'b0};
  wire [6:0] core_pri = {
    sic[SIC_T0P], // [R15]
    sic[SIC_RBP], // [R16]
    1'b1, // [R13]
    sic[SIC_X3P], tic[TIC_X2P], tic[TIC_X1P], // [R12]
    1'b0};
  wire [7:0] p2 = periph_pending2 & PPG2_WMASK;
  wire [7:0] p3 = periph_pending3 & 8'h76;

  // Routing onto the two request lines.
  wire ple = rcpc[RCPC_PLE];
  wire glob_en = mic[MIC_GLB_EN];
  wire peri_en = mic[MIC_PER_EN];
  wire hi_pend = |(core_pend & core_pri) | |(p2 & ppg2) | |(p3 & ppg3);
  wire lo_pend = |(core_pend & ~core_pri) | |(p2 & ~ppg2) | |(p3 & ~ppg3);
  wire any_pend = |core_pend | (peri_en & (|p2 | |p3)); // [R19]
  assign irq_high = ple ? (glob_en & hi_pend & ~in_high) // [R20] [R21]
                        : (glob_en & any_pend & ~in_high); // [R6]
  assign irq_low = ple & glob_en & peri_en & lo_pend &
                   ~in_high & ~in_low; // [R21]
  assign wake = |({tic[TIC_FLAG_LSB +: 3], mic[MIC_X0F]} &
                  {tic[TIC_EN_LSB +: 3], mic[MIC_X0E]}); // [R11]

  // Service state; a high request may nest inside low service.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_high <= 1'b0;
      in_low <= 1'b0;
    end else if (irq_take) begin
      if (irq_take_high) in_high <= 1'b1; // [R21]
      else in_low <= 1'b1;
    end else if (irq_return) begin
      if (in_high) in_high <= 1'b0;
      else in_low <= 1'b0;
    end
  end

  // Context capture on interrupt entry.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_push <= 1'b0;
      stack_pc <= 21'h00_0000;
      fast_work <= 8'h00;
      fast_status <= 8'h00;
      fast_bank <= 8'h00;
    end else begin
      stack_push <= irq_take; // [R17]
      if (irq_take) begin
        stack_pc <= core_pc;
        fast_work <= core_work;
        fast_status <= core_status;
        fast_bank <= core_bank;
      end
    end
  end

  // Read selection; unimplemented bits come back as zero.
  assign rd_data =
    rd_addr == OFF_PPG2 ? ppg2 :
    rd_addr == OFF_PPG3 ? ppg3 :
    rd_addr == OFF_RCPC ? rcpc :
    rd_addr == OFF_MIC ? mic :
    rd_addr == OFF_SIC ? sic :
    rd_addr == OFF_TIC ? tic :
    rd_addr == OFF_T0CTL ? t0ctl :
    rd_addr == OFF_T0LO ? t0count[7:0] :
    rd_addr == OFF_T0HI ? t0count[15:8] :
    rd_addr == OFF_SVC ? {4'h0, irq_low, irq_high, in_low, in_high} :
    8'h00;
  assign rd_hit = rd_addr inside {OFF_PPG2, OFF_PPG3, OFF_RCPC, OFF_MIC,
                  OFF_SIC, OFF_TIC, OFF_T0CTL, OFF_T0LO, OFF_T0HI, OFF_SVC};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ppg2_write;
    wr_ppg2 |=> ppg2 == ($past(wr_data) & PPG2_WMASK);
  endproperty
  a_ppg2_write: assert property (p_ppg2_write) // [R1] [R2]
    else $error("group 2 priority write wrong");

  property p_ppg3_fixed;
    ppg3[5:4] == 2'b00 && ppg3[7] == 1'b0 && ppg3[3] == 1'b0 && !ppg3[0];
  endproperty
  a_ppg3_fixed: assert property (p_ppg3_fixed) // [R4] [R5]
    else $error("group 3 fixed bits not zero");

  property p_ppg3_write;
    wr_ppg3 |=> ppg3[6] == $past(wr_data[6]) && ppg3[2:1] == $past(wr_data[2:1]);
  endproperty
  a_ppg3_write: assert property (p_ppg3_write) // [R3] [R5]
    else $error("group 3 priority write wrong");

  property p_rcpc_ro;
    ##1 rcpc[3:2] == 2'b11 && rcpc[6:5] == 2'b00;
  endproperty
  a_rcpc_ro: assert property (p_rcpc_ro) // [R7]
    else $error("reset cause read-only bits moved");

  property p_single_level;
    !ple |-> !irq_low;
  endproperty
  a_single_level: assert property (p_single_level) // [R6] [R20]
    else $error("low line used without priority levels");

  property p_periph_gate;
    !ple && core_pend == 7'h00 && !peri_en |-> !irq_high;
  endproperty
  a_periph_gate: assert property (p_periph_gate) // [R19]
    else $error("peripheral request passed without enable");

  property p_ext_flag;
    ext_evt[1] |=> tic[TIC_FLAG_LSB];
  endproperty
  a_ext_flag: assert property (p_ext_flag) // [R9]
    else $error("pin edge did not set its flag");

  property p_ext0_high;
    ple && glob_en && !in_high && mic[MIC_X0F] && mic[MIC_X0E] |-> irq_high;
  endproperty
  a_ext0_high: assert property (p_ext0_high) // [R13]
    else $error("external zero not high priority");

  property p_t0_wrap8;
    !mode16 && timer0_tick && t0count[7:0] == 8'hFF |=>
      mic[MIC_T0F] && t0count[7:0] == 8'h00;
  endproperty
  a_t0_wrap8: assert property (p_t0_wrap8) // [R14]
    else $error("timer0 wrap did not set flag");

  property p_rb_change;
    port_b_pins != $past(port_b_pins) |=> mic[MIC_RBF];
  endproperty
  a_rb_change: assert property (p_rb_change) // [R16]
    else $error("port B change flag not set");

  property p_wake;
    mic[MIC_X0F] && mic[MIC_X0E] |-> wake;
  endproperty
  a_wake: assert property (p_wake) // [R11]
    else $error("enabled pin flag gave no wake");

  property p_preempt;
    in_low |-> !irq_low;
  endproperty
  a_preempt: assert property (p_preempt) // [R21]
    else $error("low request during low service");

  sequence s_take;
    irq_take;
  endsequence
  sequence s_saved;
    stack_push && fast_work == $past(core_work) &&
      fast_bank == $past(core_bank) && stack_pc == $past(core_pc);
  endsequence
  property p_context;
    s_take |=> s_saved ##1 !stack_push || $past(irq_take);
  endproperty
  a_context: assert property (p_context) // [R17]
    else $error("context not captured on entry");

endmodule // irq_prio_core
`default_nettype wire

// File: irq_prio_pkg.sv
// Constants shared by the prioritised interrupt source block.
package irq_prio_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] OFF_PPG2 = 8'h00;
  localparam logic [7:0] OFF_PPG3 = 8'h04;
  localparam logic [7:0] OFF_RCPC = 8'h08;
  localparam logic [7:0] OFF_MIC = 8'h0C;
  localparam logic [7:0] OFF_SIC = 8'h10;
  localparam logic [7:0] OFF_TIC = 8'h14;
  localparam logic [7:0] OFF_T0CTL = 8'h18;
  localparam logic [7:0] OFF_T0LO = 8'h1C;
  localparam logic [7:0] OFF_T0HI = 8'h20;
  localparam logic [7:0] OFF_SVC = 8'h24;

  // Reset values and writable masks of the stored registers.
  localparam logic [7:0] PPG2_RST = 8'hCE;
  localparam logic [7:0] PPG2_WMASK = 8'hCE;
  localparam logic [7:0] PPG3_RST = 8'h06;
  localparam logic [7:0] PPG3_WMASK = 8'h46;
  localparam logic [7:0] RCPC_RST = 8'h1C;
  localparam logic [7:0] RCPC_WMASK = 8'h93;
  localparam logic [7:0] MIC_RST = 8'h00;
  localparam logic [7:0] SIC_RST = 8'h7F;
  localparam logic [7:0] SIC_WMASK = 8'h7F;
  localparam logic [7:0] TIC_RST = 8'hC0;
  localparam logic [7:0] T0CTL_RST = 8'h00;
  localparam logic [7:0] T0CTL_WMASK = 8'h01;

  // Field positions.
  localparam int RCPC_PLE = 7;
  localparam int MIC_GLB_EN = 7;
  localparam int MIC_PER_EN = 6;
  localparam int MIC_T0E = 5;
  localparam int MIC_X0E = 4;
  localparam int MIC_RBE = 3;
  localparam int MIC_T0F = 2;
  localparam int MIC_X0F = 1;
  localparam int MIC_RBF = 0;
  localparam int SIC_POL_LSB = 3;
  localparam int SIC_T0P = 2;
  localparam int SIC_X3P = 1;
  localparam int SIC_RBP = 0;
  localparam int TIC_X2P = 7;
  localparam int TIC_X1P = 6;
  localparam int TIC_EN_LSB = 3;
  localparam int TIC_FLAG_LSB = 0;
  localparam int T0CTL_MODE16 = 0;

  // Timer0 wrap points and bus response codes.
  localparam logic [7:0] T0_WRAP8 = 8'hFF;
  localparam logic [15:0] T0_WRAP16 = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: prioritized_interrupt_sources_tb.sv
// Self-checking bench for the prioritised interrupt source block.
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_sources_tb import irq_prio_pkg::*;;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, accept = 1'h0;
  logic timer0_tick = 1'h0, ret_go = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pend2 = 8'h00, pend3 = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF, strb = 4'hF, ext_pins = 4'h0;
  logic [7:4] port_b_pins = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_high, irq_low;
  logic wake, irq_take, take_hi, irq_return, stack_push;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] work, status, bank, f_work, f_status, f_bank, tv, fa, fv;
  logic [20:0] pc, stack_pc;
  logic [44:0] ctx;
  logic [7:0] ra [3] = '{OFF_PPG2, OFF_PPG3, OFF_RCPC};
  logic [7:0] rv [3] = '{8'hCE, 8'h06, 8'h1C};
  logic [7:0] ov [3] = '{8'hCE, 8'h46, 8'h9F};
  logic [7:0] zv [3] = '{8'h00, 8'h00, 8'h0C};
  int miscompares = 0, tests_run = 0, cycles = 0;

  irq_prio_core u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_pins(ext_pins), .port_b_pins(port_b_pins),
    .timer0_tick(timer0_tick), .periph_pending2(pend2),
    .periph_pending3(pend3), .irq_high(irq_high), .irq_low(irq_low),
    .wake(wake), .irq_take(irq_take), .irq_take_high(take_hi),
    .irq_return(irq_return), .core_pc(pc), .core_work(work),
    .core_status(status), .core_bank(bank), .stack_push(stack_push),
    .stack_pc(stack_pc), .fast_work(f_work), .fast_status(f_status),
    .fast_bank(f_bank)
  );

  irq_core_model #(.LATENCY(3)) u_core (
    .aclk(aclk), .aresetn(aresetn), .accept(accept), .ret_go(ret_go),
    .irq_high(irq_high), .irq_low(irq_low), .irq_take(irq_take),
    .irq_take_high(take_hi), .irq_return(irq_return), .core_pc(pc),
    .core_work(work), .core_status(status), .core_bank(bank)
  );

  // Free-running 25 MHz clock.
  initial begin
    forever #20 aclk = ~aclk;
  end

  // Cuts a hung run short.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      summarize();
    end
  end

  // Core context as the core offered it at the take.
  always @(posedge aclk) begin
    if (irq_take) begin
      ctx <= {pc, work, status, bank};
    end
  end

  task automatic summarize();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares both request lines once they have settled.
  task automatic lines(input logic h, input logic l);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check({30'h0, irq_high, irq_low}, {30'h0, h, l});
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ah, wh, ad, wd, b;
    ad = 1'h0;
    wd = 1'h0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= strb;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      ad = ad | ah;
      wd = wd | wh;
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
    end
    do begin
      @(negedge aclk);
      b = bvalid;
      rs = bresp;
      @(posedge aclk);
    end while (!b);
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er = RESP_OKAY);
    logic v;
    logic [31:0] d;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      v = arready;
      @(posedge aclk);
    end while (!v);
    arvalid <= 1'h0;
    do begin
      @(negedge aclk);
      v = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
    end while (!v);
    rready <= 1'h0;
    @(posedge aclk);
    check(d, e);
    check({30'h0, rs}, {30'h0, er});
  endtask

  // Holds the timer tick for n cycles, then lets the flag land.
  task automatic ticks(input int n);
    timer0_tick <= 1'h1;
    repeat (n) @(posedge aclk);
    timer0_tick <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask

  // Main sequence.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    strb = 4'h0;
    wr(OFF_PPG2, 8'h00);
    check({30'h0, rs}, {30'h0, RESP_OKAY});
    strb = 4'hF;
    for (int k = 0; k < 3; k++) begin
      rd_chk(ra[k], rv[k]);
      wr(ra[k], 8'hFF);
      rd_chk(ra[k], ov[k]);
      wr(ra[k], 8'h00);
      rd_chk(ra[k], zv[k]);
    end
    rd_chk(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 8'hFF);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 4; i++) begin
      for (int p = 0; p < 2; p++) begin
        fa = i ? OFF_TIC : OFF_MIC;
        fv = i ? 8'h01 << (i - 1) : 8'h02;
        wr(OFF_SIC, p ? 8'h08 << i : 8'h00);
        ext_pins[i] <= p[0];
        wr(OFF_MIC, 8'h00);
        wr(OFF_TIC, 8'h00);
        ext_pins[i] <= !p;
        repeat (4) @(posedge aclk);
        rd_chk(fa, 32'h0);
        ext_pins[i] <= p[0];
        repeat (4) @(posedge aclk);
        rd_chk(fa, {24'h0, fv});
      end
    end
    wr(OFF_TIC, 8'h24);
    @(negedge aclk);
    check({31'h0, wake}, 32'h1);
    @(posedge aclk);
    wr(OFF_MIC, 8'h80);
    lines(1'h1, 1'h0);
    wr(OFF_TIC, 8'h04);
    lines(1'h0, 1'h0);
    @(negedge aclk);
    check({31'h0, wake}, 32'h0);
    @(posedge aclk);
    wr(OFF_RCPC, 8'h80);
    for (int i = 0; i < 4; i++) begin
      for (int p = 0; p < 2; p++) begin
        tv = i == 0 ? 8'h00 : 8'h09 << (i - 1);
        if (p && i == 1) tv = tv | 8'h40;
        if (p && i == 2) tv = tv | 8'h80;
        wr(OFF_SIC, (p && i == 3) ? 8'h7A : 8'h78);
        wr(OFF_TIC, tv);
        wr(OFF_MIC, i ? 8'hC0 : 8'hD2);
        lines(p || i == 0, !(p || i == 0));
      end
    end
    wr(OFF_MIC, 8'h00);
    wr(OFF_TIC, 8'h00);
    port_b_pins <= 4'h1;
    repeat (4) @(posedge aclk);
    rd_chk(OFF_MIC, 32'h01);
    wr(OFF_MIC, 8'hC9);
    lines(1'h0, 1'h1);
    wr(OFF_RCPC, 8'h00);
    lines(1'h1, 1'h0);
    wr(OFF_MIC, 8'h80);
    pend2 <= 8'h80;
    lines(1'h0, 1'h0);
    wr(OFF_MIC, 8'hC0);
    lines(1'h1, 1'h0);
    wr(OFF_PPG2, 8'h00);
    wr(OFF_RCPC, 8'h80);
    lines(1'h0, 1'h1);
    pend2 <= 8'h00;
    pend3 <= 8'h10;
    lines(1'h0, 1'h1);
    wr(OFF_PPG3, 8'h02);
    pend3 <= 8'h02;
    lines(1'h1, 1'h0);
    pend3 <= 8'h00;
    wr(OFF_MIC, 8'h00);
    wr(OFF_T0CTL, 8'h01);
    ticks(65535);
    rd_chk(OFF_MIC, 32'h00);
    rd_chk(OFF_T0HI, 32'hFF);
    ticks(1);
    rd_chk(OFF_MIC, 32'h04);
    wr(OFF_MIC, 8'h00);
    wr(OFF_T0CTL, 8'h00);
    ticks(255);
    rd_chk(OFF_MIC, 32'h00);
    ticks(1);
    rd_chk(OFF_MIC, 32'h04);
    wr(OFF_MIC, 8'hE4);
    wr(OFF_SIC, 8'h7C);
    lines(1'h1, 1'h0);
    wr(OFF_SIC, 8'h78);
    lines(1'h0, 1'h1);
    accept <= 1'h1;
    do @(negedge aclk); while (!stack_push);
    check({11'h0, stack_pc}, {11'h0, ctx[44:24]});
    check({8'h0, f_work, f_status, f_bank}, {8'h0, ctx[23:0]});
    @(posedge aclk);
    accept <= 1'h0;
    lines(1'h0, 1'h0);
    wr(OFF_SIC, 8'h7C);
    lines(1'h1, 1'h0);
    rd_chk(OFF_SVC, 32'h06);
    ret_go <= 1'h1;
    @(posedge aclk);
    ret_go <= 1'h0;
    repeat (2) @(posedge aclk);
    rd_chk(OFF_SVC, 32'h04);
    accept <= 1'h1;
    do @(negedge aclk); while (!stack_push);
    @(posedge aclk);
    accept <= 1'h0;
    rd_chk(OFF_SVC, 32'h01);
    summarize();
  end
endmodule // prioritized_interrupt_sources_tb
`default_nettype wire
